// ---- scwd_top.v ----
// spindle command word decoder with axi4-lite parameter registers
`include "scwd_defs.vh"
`timescale 1ns/100ps
module scwd_top #(
	parameter NUM_GEARS = 4,
	parameter NUM_GPSEL = 12
) (
	// clock and reset
	input wire CLK_SYS,
	input wire SYS_RST,
	// control word and drive status pins
	input wire [15:0] CTRL_WORD,
	input wire [11:0] GP_INPUT,
	input wire READY_ON,
	input wire SPEED_PRESENT,
	input wire MOTOR_STOPPED,
	// decoded outputs
	output reg [1:0] GEAR_STAGE,
	output reg [14:0] SPINDLE_TEETH,
	output reg [14:0] MOTOR_TEETH,
	output reg RUN_CCW,
	output reg RUN_CW,
	output reg HOLD_STOP,
	output reg ORIENTING,
	output reg [1:0] INDEX_DIR,
	output reg LOW_COIL,
	output reg SUB_MOTOR,
	output reg DECEL,
	output reg POWER_ON,
	// axi4-lite slave
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY
);
	////////////////////////////////////////////////////////////////////////////
	// declarations
	reg [14:0] spindle_teeth [0:NUM_GEARS-1];
	reg [14:0] motor_teeth [0:NUM_GEARS-1];
	reg [4:0] gp_input_sel [0:NUM_GPSEL-1];
	reg [15:0] cmd_soft;
	reg [11:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	wire [15:0] word_s;
	wire [11:0] gp_s;
	wire [15:0] word;
	reg gear_sel_lo;
	reg gear_sel_hi;
	wire [1:0] gear;
	wire run_forward;
	wire run_reverse;
	wire orient_start;
	wire m_ccw, m_cw, m_hold, m_orient, m_decel, m_power;
	reg [31:0] next_rdata;
	reg next_rerr;
	integer i;
	integer j;

	// clamp a written tooth count into 1..32767
	function [14:0] clamp_teeth;
		input [31:0] v;
		begin
			if (v[15:0] == 16'h0000)
				clamp_teeth = `SCWD_TEETH_MIN;
			else if (v[15:0] > {1'b0, `SCWD_TEETH_MAX})
				clamp_teeth = `SCWD_TEETH_MAX;
			else
				clamp_teeth = v[14:0];
		end
	endfunction

	// clamp a selector into 0..21
	function [4:0] clamp_sel;
		input [31:0] v;
		begin
			if (v[7:0] > {3'b000, `SCWD_GPSEL_MAX})
				clamp_sel = `SCWD_GPSEL_MAX;
			else
				clamp_sel = v[4:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	scwd_sync #(.WIDTH(16)) u_word_sync (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.din(CTRL_WORD),
		.dout(word_s)
	);

	scwd_sync #(.WIDTH(12)) u_gp_sync (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.din(GP_INPUT),
		.dout(gp_s)
	);

	// pin word or'd with software command word; bits 7 and 15 dropped
	assign word = (word_s | cmd_soft) & 16'h7F7F;

	// gear select from word or from any selector routed to it
	always @*
	begin
		gear_sel_lo = word[`SCWD_BIT_GEAR_LO];
		gear_sel_hi = word[`SCWD_BIT_GEAR_HI];
		for (i = 0; i < NUM_GPSEL; i = i + 1)
		begin
			if (gp_input_sel[i] == `SCWD_GPSEL_GEAR_LO && gp_s[i])
				gear_sel_lo = 1'b1;
			if (gp_input_sel[i] == `SCWD_GPSEL_GEAR_HI && gp_s[i])
				gear_sel_hi = 1'b1;
		end
	end

	assign gear = {gear_sel_hi, gear_sel_lo};
	assign run_forward = word[`SCWD_BIT_RUN_FWD];
	assign run_reverse = word[`SCWD_BIT_RUN_REV];
	assign orient_start = word[`SCWD_BIT_ORIENT];

	////////////////////////////////////////////////////////////////////////////
	// motion sequencing
	scwd_motion u_motion (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.ready_on(READY_ON),
		.run_forward(run_forward),
		.run_reverse(run_reverse),
		.orient_start(orient_start),
		.speed_present(SPEED_PRESENT),
		.motor_stopped(MOTOR_STOPPED),
		.run_ccw(m_ccw),
		.run_cw(m_cw),
		.hold_stop(m_hold),
		.orienting(m_orient),
		.decel(m_decel),
		.power_on(m_power)
	);

	// decoded outputs registered
	always @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			GEAR_STAGE <= 2'b00;
			SPINDLE_TEETH <= `SCWD_TEETH_RST;
			MOTOR_TEETH <= `SCWD_TEETH_RST;
			RUN_CCW <= 1'b0;
			RUN_CW <= 1'b0;
			HOLD_STOP <= 1'b0;
			ORIENTING <= 1'b0;
			INDEX_DIR <= 2'b00;
			LOW_COIL <= 1'b0;
			SUB_MOTOR <= 1'b0;
			DECEL <= 1'b0;
			POWER_ON <= 1'b0;
		end
		else
		begin
			GEAR_STAGE <= gear;
			SPINDLE_TEETH <= spindle_teeth[gear];
			MOTOR_TEETH <= motor_teeth[gear];
			RUN_CCW <= m_ccw;
			RUN_CW <= m_cw;
			HOLD_STOP <= m_hold;
			ORIENTING <= m_orient;
			DECEL <= m_decel;
			POWER_ON <= m_power;
			// index bits only under orientation; both set gives none
			if (orient_start && (word[`SCWD_BIT_IDX_CCW] ^ word[`SCWD_BIT_IDX_CW]))
				INDEX_DIR <= {word[`SCWD_BIT_IDX_CW], word[`SCWD_BIT_IDX_CCW]};
			else
				INDEX_DIR <= 2'b00;
			// winding frozen while orientation is commanded
			if (!orient_start)
				LOW_COIL <= word[`SCWD_BIT_LOW_COIL];
			SUB_MOTOR <= word[`SCWD_BIT_SUB_MOTOR];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data held until both present
	always @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `SCWD_RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			cmd_soft <= 16'h0000;
			for (j = 0; j < NUM_GEARS; j = j + 1)
			begin
				spindle_teeth[j] <= `SCWD_TEETH_RST;
				motor_teeth[j] <= `SCWD_TEETH_RST;
			end
			for (j = 0; j < NUM_GPSEL; j = j + 1)
				gp_input_sel[j] <= `SCWD_GPSEL_RST;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_addr <= S_AXI_AWADDR;
				aw_held <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				w_held <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (aw_held && w_held && !S_AXI_BVALID)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `SCWD_RESP_OKAY;
				// partial strobes: cmd bytes follow their own strobes, tooth counts need both low strobes, selectors need only strobe 0
				if (aw_addr == `SCWD_REG_CMD)
				begin
					if (w_strb[0])
						cmd_soft[7:0] <= w_data[7:0];
					if (w_strb[1])
						cmd_soft[15:8] <= w_data[15:8];
				end
				else if (aw_addr[11:4] == 8'h01 && aw_addr[1:0] == 2'b00 && w_strb[1:0] == 2'b11)
					spindle_teeth[aw_addr[3:2]] <= clamp_teeth(w_data);
				else if (aw_addr[11:4] == 8'h02 && aw_addr[1:0] == 2'b00 && w_strb[1:0] == 2'b11)
					motor_teeth[aw_addr[3:2]] <= clamp_teeth(w_data);
				else if (aw_addr >= `SCWD_REG_GPSEL && aw_addr < `SCWD_REG_GPSEL_END
					&& aw_addr[1:0] == 2'b00)
				begin
					if (w_strb[0])
						gp_input_sel[aw_addr[5:2]] <= clamp_sel(w_data);
				end
				else if (aw_addr != `SCWD_REG_STATUS && aw_addr != `SCWD_REG_GEAR_RATIO)
					S_AXI_BRESP <= `SCWD_RESP_SLVERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
			begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read decode
	always @*
	begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		if (S_AXI_ARADDR == `SCWD_REG_CMD)
			next_rdata = {16'h0000, cmd_soft};
		else if (S_AXI_ARADDR == `SCWD_REG_STATUS)
			next_rdata = {16'h0000, POWER_ON, DECEL, SUB_MOTOR, LOW_COIL, INDEX_DIR,
				ORIENTING, HOLD_STOP, RUN_CW, RUN_CCW, GEAR_STAGE, 4'h0};
		else if (S_AXI_ARADDR == `SCWD_REG_GEAR_RATIO)
			next_rdata = {1'b0, MOTOR_TEETH, 1'b0, SPINDLE_TEETH};
		else if (S_AXI_ARADDR[11:4] == 8'h01 && S_AXI_ARADDR[1:0] == 2'b00)
			next_rdata = {17'h0_0000, spindle_teeth[S_AXI_ARADDR[3:2]]};
		else if (S_AXI_ARADDR[11:4] == 8'h02 && S_AXI_ARADDR[1:0] == 2'b00)
			next_rdata = {17'h0_0000, motor_teeth[S_AXI_ARADDR[3:2]]};
		else if (S_AXI_ARADDR >= `SCWD_REG_GPSEL && S_AXI_ARADDR < `SCWD_REG_GPSEL_END
			&& S_AXI_ARADDR[1:0] == 2'b00)
			next_rdata = {27'h000_0000, gp_input_sel[S_AXI_ARADDR[5:2]]};
		else
			next_rerr = 1'b1;
	end

	// axi4-lite read channel
	always @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `SCWD_RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rerr ? `SCWD_RESP_SLVERR : `SCWD_RESP_OKAY;
		end
		else if (S_AXI_RVALID && S_AXI_RREADY)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end
endmodule

// ---- scwd_defs.vh ----
// constants for the spindle command word decoder
`ifndef SCWD_DEFS_VH
`define SCWD_DEFS_VH
////////////////////////////////////////////////////////////////////////////////
// control word bit positions
`define SCWD_BIT_GEAR_LO 5
`define SCWD_BIT_GEAR_HI 6
`define SCWD_BIT_RUN_FWD 8
`define SCWD_BIT_RUN_REV 9
`define SCWD_BIT_IDX_CCW 10
`define SCWD_BIT_IDX_CW 11
`define SCWD_BIT_ORIENT 12
`define SCWD_BIT_LOW_COIL 13
`define SCWD_BIT_SUB_MOTOR 14
////////////////////////////////////////////////////////////////////////////////
// parameter limits and reset values
`define SCWD_TEETH_MIN 15'h0001
`define SCWD_TEETH_MAX 15'h7FFF
`define SCWD_TEETH_RST 15'h0001
`define SCWD_GPSEL_MAX 5'h15
`define SCWD_GPSEL_RST 5'h00
`define SCWD_GPSEL_GEAR_LO 5'h07
`define SCWD_GPSEL_GEAR_HI 5'h08
////////////////////////////////////////////////////////////////////////////////
// register byte offsets and bus response codes
`define SCWD_REG_CMD 12'h000
`define SCWD_REG_STATUS 12'h004
`define SCWD_REG_SPD_TEETH 12'h010
`define SCWD_REG_MOT_TEETH 12'h020
`define SCWD_REG_GPSEL 12'h040
`define SCWD_REG_GPSEL_END 12'h070
`define SCWD_REG_GEAR_RATIO 12'h080
`define SCWD_RESP_OKAY 2'b00
`define SCWD_RESP_SLVERR 2'b10
`endif

// ---- scwd_sync.v ----
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module scwd_sync #(
	parameter WIDTH = 16
) (
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta;

	// first flop feeds only the second
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// ---- scwd_motion.v ----
// run, stop and orientation sequencing from decoded command bits
`include "scwd_defs.vh"
`timescale 1ns/100ps
module scwd_motion (
	input wire clk,
	input wire rst,
	input wire ready_on,
	input wire run_forward,
	input wire run_reverse,
	input wire orient_start,
	input wire speed_present,
	input wire motor_stopped,
	output reg run_ccw,
	output reg run_cw,
	output reg hold_stop,
	output reg orienting,
	output reg decel,
	output reg power_on
);
	wire fwd_ok;
	wire rev_ok;
	wire any_run;

	// run bits count only with ready on
	assign fwd_ok = run_forward & ready_on;
	assign rev_ok = run_reverse & ready_on;
	assign any_run = fwd_ok | rev_ok;

	// priority: orientation, both-run stop, single run, deceleration
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			run_ccw <= 1'b0;
			run_cw <= 1'b0;
			hold_stop <= 1'b0;
			orienting <= 1'b0;
			decel <= 1'b0;
			power_on <= 1'b0;
		end
		else
		begin
			orienting <= orient_start;
			hold_stop <= ~orient_start & fwd_ok & rev_ok;
			// rotation resumes when orientation drops and a run bit stands
			run_ccw <= ~orient_start & fwd_ok & ~rev_ok & speed_present;
			run_cw <= ~orient_start & rev_ok & ~fwd_ok & speed_present;
			if (orient_start | any_run)
			begin
				power_on <= 1'b1;
				decel <= 1'b0;
			end
			else if (power_on & ~motor_stopped)
				decel <= 1'b1;
			else
			begin
				decel <= 1'b0;
				power_on <= 1'b0;
			end
		end
	end
endmodule

// ---- scwd_nc_model.sv ----
// controller model driving the control word pins
`timescale 1ns/100ps
module scwd_nc_model (
	// clock
	input wire clk,
	// command word to the drive
	output reg [15:0] word
);
	initial word = 16'h0000;
	// bits 7 and 15 go out as zero, both index bits never together
	task put(input [15:0] w);
	begin
		@(posedge clk);
		word <= (w[11:10] == 2'b11) ? (w & 16'h737F) : (w & 16'h7F7F);
	end
	endtask
endmodule

// ---- scwd_top_asserts.sv ----
// port checks for the spindle command word decoder
`timescale 1ns/100ps
module scwd_chk (
	// clock and reset
	input wire CLK_SYS,
	input wire SYS_RST,
	// pins
	input wire [15:0] CTRL_WORD,
	input wire [11:0] GP_INPUT,
	input wire READY_ON,
	input wire SPEED_PRESENT,
	input wire MOTOR_STOPPED,
	// decoded outputs
	input wire [1:0] GEAR_STAGE,
	input wire RUN_CCW,
	input wire RUN_CW,
	input wire HOLD_STOP,
	input wire [1:0] INDEX_DIR,
	input wire LOW_COIL,
	input wire SUB_MOTOR,
	input wire DECEL,
	input wire POWER_ON
);
	wire [15:0] w;
	wire [29:0] pins;
	reg [29:0] prv;
	reg [2:0] cnt;
	wire [2:0] st;
	assign w = CTRL_WORD;
	assign pins = {w, GP_INPUT, READY_ON, SPEED_PRESENT};
	// a pin change clears the count at once, not one edge late
	assign st = (prv == pins) ? cnt : 3'h0;
	// edges the pins held still, so the pipeline has settled
	always @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			prv <= 30'h0000_0000;
			cnt <= 3'h0;
		end
		else
		begin
			prv <= pins;
			if (prv != pins)
				cnt <= 3'h0;
			else if (cnt != 3'h7)
				cnt <= cnt + 3'h1;
		end
	end
	////////////////////////////////////////
	// decoded outputs against a settled word
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);
	property p_gear; st > 3'h3 && GP_INPUT == 12'h000 |-> GEAR_STAGE == w[6:5]; endproperty
	a_gear: assert property (p_gear) else $error("gear stage wrong");
	property p_fwd;
		st > 3'h3 && READY_ON |-> RUN_CCW == (w[8] && !w[9] && !w[12] && SPEED_PRESENT);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward run wrong");
	property p_rev;
		st > 3'h3 && READY_ON |-> RUN_CW == (w[9] && !w[8] && !w[12] && SPEED_PRESENT);
	endproperty
	a_rev: assert property (p_rev) else $error("reverse run wrong");
	property p_both; st > 3'h3 && READY_ON && !w[12] |-> HOLD_STOP == (w[8] && w[9]); endproperty
	a_both: assert property (p_both) else $error("hold stop wrong");
	property p_rdy; st > 3'h3 && !READY_ON |-> !RUN_CCW && !RUN_CW; endproperty
	a_rdy: assert property (p_rdy) else $error("run without ready");
	property p_idx;
		st > 3'h3 |-> INDEX_DIR == ((w[12] && w[11:10] != 2'b11) ? w[11:10] : 2'b00);
	endproperty
	a_idx: assert property (p_idx) else $error("index direction wrong");
	property p_frz; w[12] [*5] |-> $stable(LOW_COIL); endproperty
	a_frz: assert property (p_frz) else $error("coil moved in orientation");
	property p_sub; st > 3'h3 |-> SUB_MOTOR == w[14]; endproperty
	a_sub: assert property (p_sub) else $error("motor choice wrong");
	property p_off; $fell(POWER_ON) && !$past(SYS_RST) |-> $past(MOTOR_STOPPED); endproperty
	a_off: assert property (p_off) else $error("power off before standstill");
	property p_dec; DECEL |-> POWER_ON; endproperty
	a_dec: assert property (p_dec) else $error("decel without power");
	c_hold: cover property (HOLD_STOP);
	c_idx: cover property (INDEX_DIR == 2'b10);
	c_off: cover property ($fell(POWER_ON));
endmodule
bind scwd_top scwd_chk u_chk (.CLK_SYS, .SYS_RST, .CTRL_WORD, .GP_INPUT, .READY_ON,
	.SPEED_PRESENT, .MOTOR_STOPPED,
	.GEAR_STAGE, .RUN_CCW, .RUN_CW, .HOLD_STOP, .INDEX_DIR, .LOW_COIL, .SUB_MOTOR,
	.DECEL, .POWER_ON);

// ---- spindle_command_word_decoder_tb.sv ----
// self-checking bench for the spindle command word decoder
`timescale 1ns/100ps
module spindle_command_word_decoder_tb;
	reg clk, rst, rdy, stp, spd, awv, wv, bre, arv, rre;
	reg [11:0] gp, awa, ara, k;
	reg [31:0] wd, rd;
	reg [3:0] ws;
	reg [1:0] rr, wbr;
	wire [15:0] cw;
	wire [1:0] gs, ix, br, rs;
	wire [14:0] st, mt;
	wire rccw, rcw, hs, ori, lc, sm, dec, pw, awr, wr, bv, arr, rv;
	wire [31:0] rdat;
	wire [11:0] outs;
	integer num_errors, n_tests;
	assign outs = {pw, dec, sm, lc, ix, ori, hs, rcw, rccw, gs};
	scwd_nc_model u_nc (.clk(clk), .word(cw));
	scwd_top u_dut (.CLK_SYS(clk), .SYS_RST(rst), .CTRL_WORD(cw), .GP_INPUT(gp),
		.READY_ON(rdy), .SPEED_PRESENT(spd), .MOTOR_STOPPED(stp), .GEAR_STAGE(gs),
		.SPINDLE_TEETH(st), .MOTOR_TEETH(mt), .RUN_CCW(rccw), .RUN_CW(rcw),
		.HOLD_STOP(hs), .ORIENTING(ori), .INDEX_DIR(ix), .LOW_COIL(lc), .SUB_MOTOR(sm),
		.DECEL(dec), .POWER_ON(pw), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
	// free-running system clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////
	// compare and count
	task chk(input [31:0] g, input [31:0] e, input [63:0] nm);
	begin
		n_tests = n_tests + 1;
		if (g !== e)
		begin
			$display("unexpected %0s exp %0h got %0h", nm, e, g);
			num_errors = num_errors + 1;
		end
	end
	endtask
	// bus write, address and data offered together
	task axw(input [11:0] a, input [31:0] d);
	begin
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		@(posedge clk);
		// each channel drops its valid at the edge that took it
		while (!bv)
		begin
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
			@(posedge clk);
		end
		wbr = br;
		bre <= 1'b0;
	end
	endtask
	// bus read, data and response taken at the handshake edge
	task axr(input [11:0] a);
	begin
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		rd = rdat;
		rr = rs;
		rre <= 1'b0;
	end
	endtask
	// apply ready, standstill and word, then compare all decoded outputs except the tooth counts
	task step(input [1:0] r, input [11:0] e, input [15:0] w);
	begin
		@(posedge clk);
		rdy <= r[1];
		stp <= r[0];
		u_nc.put(w);
		repeat (6) @(posedge clk);
		#1;
		chk({20'h0_0000, outs}, {20'h0_0000, e}, "outputs");
	end
	endtask
	////////////////////////////////////////
	// reset values, clamping and an unmapped read
	task t_regs;
	begin
		axr(12'h01C);
		chk(rd, 32'h0000_0001, "spd_rst");
		axr(12'h02C);
		chk(rd, 32'h0000_0001, "mot_rst");
		axw(12'h010, 32'h0000_0000);
		axr(12'h010);
		chk(rd, 32'h0000_0001, "spd_min");
		axw(12'h020, 32'h0000_8000);
		axr(12'h020);
		chk(rd, 32'h0000_7FFF, "mot_max");
		axw(12'h048, 32'h0000_0016);
		axr(12'h048);
		chk(rd, 32'h0000_0015, "sel_max");
		axr(12'h100);
		chk({30'h0000_0000, rr}, 32'h0000_0002, "unmapped");
		axw(12'h100, 32'h0000_0000);
		chk({30'h0000_0000, wbr}, 32'h0000_0002, "wr_unmap");
		axr(12'h080);
		chk(rd, 32'h7FFF_0001, "ratio");
		$display("register test done");
	end
	endtask
	// every gear code picks its tooth pair, inputs can drive the gear bits
	task t_gear;
	begin
		for (k = 12'h000; k < 12'h00D; k = k + 12'h004)
		begin
			axw(12'h010 + k, {20'h0_0000, 12'h00A + k});
			axw(12'h020 + k, {20'h0_0000, 12'h014 + k});
		end
		for (k = 12'h000; k < 12'h004; k = k + 12'h001)
		begin
			step(2'b11, {10'h000, k[1:0]}, {9'h000, k[1:0], 5'h00});
			chk({17'h0_0000, st}, {20'h0_0000, 12'h00A + {k[9:0], 2'b00}}, "sp_teeth");
			chk({17'h0_0000, mt}, {20'h0_0000, 12'h014 + {k[9:0], 2'b00}}, "mo_teeth");
		end
		axw(12'h040, 32'h0000_0007);
		axw(12'h044, 32'h0000_0008);
		@(posedge clk);
		gp <= 12'h001;
		step(2'b11, 12'h001, 16'h0000);
		@(posedge clk);
		gp <= 12'h002;
		step(2'b11, 12'h002, 16'h0000);
		@(posedge clk);
		gp <= 12'h000;
		$display("gear test done");
	end
	endtask
	// run, hold, orientation, indexing, coil, motor choice and stopping
	task t_motion;
	begin
		@(posedge clk);
		spd <= 1'b0;
		step(2'b10, 12'h800, 16'h0100);
		@(posedge clk);
		spd <= 1'b1;
		step(2'b10, 12'h804, 16'h0100);
		step(2'b10, 12'h810, 16'h0300);
		step(2'b10, 12'h808, 16'h0200);
		step(2'b10, 12'h820, 16'h1100);
		step(2'b10, 12'h860, 16'h1500);
		step(2'b10, 12'h8A0, 16'h1900);
		step(2'b10, 12'h820, 16'h3100);
		step(2'b10, 12'h904, 16'h2100);
		step(2'b10, 12'hA04, 16'h4500);
		step(2'b10, 12'hC03, 16'h0060);
		step(2'b11, 12'h003, 16'h0060);
		step(2'b01, 12'h000, 16'h0100);
		$display("motion test done");
	end
	endtask
	// print the counts and the verdict, then stop
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	// main sequence
	initial
	begin
		num_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		{rdy, stp, awv, wv, bre, arv, rre} = 7'h00;
		spd = 1'b1;
		ws = 4'hF;
		gp = 12'h000;
		awa = 12'h000;
		ara = 12'h000;
		wd = 32'h0000_0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_gear;
		t_motion;
		give_verdict;
	end
	// watchdog against a hung handshake
	initial
	begin
		#100000;
		num_errors = num_errors + 1;
		give_verdict;
	end
endmodule
